// [logic/hif_pkg.sv]
// package: offsets, field positions, reset values and timing of the irq/fifo block
package hif_pkg;
  // buffer geometry
  localparam int unsigned FIFO_DEPTH = 512;
  localparam int unsigned PTR_W = 9;
  localparam int unsigned CNT_W = 10;
  localparam logic [9:0] FIFO_FULL_CNT = 10'h200;
  localparam int unsigned NUM_STAT = 4;
  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_STAT = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h20;
  localparam logic [7:0] OFS_FDATA = 8'h24;
  localparam logic [7:0] OFS_FSTAT = 8'h28;
  localparam logic [7:0] OFS_WLVL = 8'h2C;
  localparam logic [7:0] OFS_TXLEN = 8'h30;
  localparam logic [7:0] OFS_MODE = 8'h34;
  localparam logic [7:0] OFS_CTRL = 8'h38;
  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned CMD_DEFAULT_BIT = 0;
  localparam int unsigned CMD_STOP_BIT = 1;
  localparam int unsigned CMD_CLRF_BIT = 2;
  localparam int unsigned FST_OVF_BIT = 12;
  localparam int unsigned FST_UNF_BIT = 13;
  localparam int unsigned MODE_RATE_LSB = 4;
  localparam int unsigned MODE_AUTO_BIT = 3;
  localparam int unsigned MAIN_WL_BIT = 3;
  localparam int unsigned MAIN_RXE_BIT = 4;
  localparam int unsigned TMR_RATE_BIT = 0;
  localparam int unsigned ERR_EON_BIT = 1;
  localparam int unsigned PT_SLWL_BIT = 2;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_RXEN_BIT = 1;
  //////////////////////////////////////////////////////////////////////////////
  // values after reset or set-default
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [9:0] WLVL_RST = 10'h040;
  localparam logic [12:0] TXLEN_RST = 13'h0000;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // slot numbers: 24 in store, warn when four remain
  localparam logic [4:0] TSN_TOTAL = 5'h18;
  localparam logic [4:0] TSN_LOW = 5'h04;
  localparam logic [4:0] SLOT_LOW_AT = TSN_TOTAL - TSN_LOW - 5'h01;
  // wake window after field detection
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned WAKE_TIME_MS = 10;
  localparam int unsigned WAKE_CYC = WAKE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_W = 18;
  typedef enum logic {WK_SLEEP, WK_AWAKE} hif_wake_t;
endpackage

// [logic/hif_fifo_if.sv]
// interface between the register side and the byte buffer
interface hif_fifo_if;
  import hif_pkg::*;
  logic push;
  logic [7:0] wdata;
  logic pop;
  logic [7:0] rdata;
  logic clr;
  logic [CNT_W-1:0] count;
  logic full;
  logic empty;
  modport src (output push, output wdata, output pop, output clr,
               input rdata, input count, input full, input empty);
  modport mem (input push, input wdata, input pop, input clr,
               output rdata, output count, output full, output empty);
endinterface

// [logic/hif_fifo.sv]
// 512-byte circular byte buffer with pointer reset
module hif_fifo
  import hif_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  hif_fifo_if.mem f
);
  logic [7:0] mem_ff [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ff;
  logic [PTR_W-1:0] rd_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic do_push;
  logic do_pop;
  logic [CNT_W-1:0] nxt_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // overfull pushes and empty pops are dropped here, the flags live outside
  assign do_push = f.push & ~f.full;
  assign do_pop = f.pop & ~f.empty;
  assign nxt_cnt = cnt_ff + CNT_W'(do_push) - CNT_W'(do_pop);
  assign f.full = (cnt_ff == FIFO_FULL_CNT);
  assign f.empty = (cnt_ff == '0);
  assign f.count = cnt_ff;
  // empty buffer reads as zero, so stale bytes never leak out
  assign f.rdata = f.empty ? 8'h00 : mem_ff[rd_ff];

  // storage has no reset; only pointers and count matter
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_ff[wr_ff] <= f.wdata;
    end
  end

  // pointers wrap by width; clear wins over traffic in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else if (f.clr) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= wr_ff + PTR_W'(do_push);
      rd_ff <= rd_ff + PTR_W'(do_pop);
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // hif_fifo

// [logic/hif_irq_fifo.sv]
// interrupt status, masking and 512-byte buffer bookkeeping behind classic wishbone
//
// Contract
// R1: interrupt status kept in four registers: main, timer, error, passive target.
// R2: an event sets its status bit and, if unmasked, raises IRQ.
// R3: host reads the main status register first after IRQ rises.
// R4: reading a status register returns its content then clears it.
// R5: IRQ stays high until the last contributing pending bit is read.
// R6: masked events still set status but never raise IRQ.
// R7: status reads report and clear masked bits too.
// R8: unmasking an already set bit raises IRQ at once.
// R9: set-default, status read, stop-all and clear-buffer clear status and IRQ.
// R10: 512-byte buffer feeds transmit framing and stores received bytes.
// R11: buffer status register carries overflow and underflow flags.
// R12: receive writes beyond 512 bytes set overflow.
// R13: host writes beyond capacity during transmit set overflow.
// R14: any read from an empty buffer sets underflow.
// R15: host must supply the full transmit count in time, else underflow.
// R16: pointers and buffer status reset at receive start, reset, default, clear.
// R17: reading an empty or cleared buffer returns zero.
// R18: in rate detection mode, receive start raises rate interrupt and latches rate.
// R19: slot interrupt when only four unused slot numbers remain.
// R20: field-on in low power wakes front end; host confirms within 10 ms.
// R21: during transmit, count falling below water level raises interrupt.
// R22: end of receive raises interrupt; count readable in buffer status.
// R23: IRQ is OR over all registers of pending bits and inverted masks.
//
// Local design decisions: the register offsets and the Wishbone register port.
module hif_irq_fifo
  import hif_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic WB_ACK_O,
  output logic [31:0] WB_DAT_O,
  input wire logic [7:0] EVT_MAIN,
  input wire logic [7:0] EVT_TIMER,
  input wire logic [7:0] EVT_ERR,
  input wire logic [7:0] EVT_PT,
  input wire logic TARGET_MODE,
  input wire logic TX_ACTIVE,
  input wire logic TX_POP,
  input wire logic RX_START,
  input wire logic RX_PUSH,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_END,
  input wire logic [1:0] RATE_IN,
  input wire logic SLOT_USE,
  input wire logic SLOT_RELOAD,
  input wire logic FIELD_ON,
  output logic IRQ,
  output logic [7:0] TX_DATA,
  output logic [12:0] TX_LEN,
  output logic [3:0] OP_MODE,
  output logic FIELD_WAKE
);
  hif_fifo_if f ();
  logic ack_ff;
  logic [31:0] dat_ff;
  logic irq_ff;
  logic [7:0] stat_ff [NUM_STAT];
  logic [7:0] mask_ff [NUM_STAT];
  logic [7:0] nxt_stat [NUM_STAT];
  logic [7:0] nxt_mask [NUM_STAT];
  logic [7:0] evt [NUM_STAT];
  logic [NUM_STAT-1:0] pend;
  logic [NUM_STAT-1:0] cur_pend;
  logic [9:0] wlvl_ff;
  logic [12:0] txlen_ff;
  logic [3:0] mode_ff;
  logic [1:0] rate_ff;
  logic [2:0] ctrl_ff;
  logic ovf_ff;
  logic unf_ff;
  logic wl_below_ff;
  logic [7:0] tx_data_ff;
  logic [4:0] slot_used_ff;
  hif_wake_t wake_ff;
  hif_wake_t nxt_wake;
  logic [WAKE_W-1:0] wake_cnt_ff;
  logic field_wake_ff;

  //////////////////////////////////////////////////////////////////////////////
  // address decode; one-cycle answer, ack drops the cycle after
  function automatic logic grp_hit(input logic [7:0] adr, input logic [7:0] base);
    grp_hit = (adr[7:4] == base[7:4]) && (adr[1:0] == 2'h0);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  logic req;
  logic rd_req;
  logic wr_req;
  logic stat_hit;
  logic mask_hit;
  logic mask_wr_any;
  logic [1:0] idx;
  logic cmd_wr;
  logic set_def;
  logic clr_all;
  logic fifo_clr;
  logic host_push;
  logic host_pop;
  logic [15:0] wlvl_m;
  logic [15:0] txlen_m;
  logic [31:0] fstat;
  logic [31:0] rd_mux;
  assign req = WB_CYC_I & WB_STB_I & ~ack_ff;
  assign rd_req = req & ~WB_WE_I;
  assign wr_req = req & WB_WE_I;
  assign stat_hit = grp_hit(WB_ADR_I, OFS_STAT);
  assign mask_hit = grp_hit(WB_ADR_I, OFS_MASK);
  assign mask_wr_any = wr_req & mask_hit & WB_SEL_I[0];
  assign idx = WB_ADR_I[3:2];
  assign cmd_wr = wr_req & (WB_ADR_I == OFS_CMD) & WB_SEL_I[0];
  assign set_def = cmd_wr & WB_DAT_I[CMD_DEFAULT_BIT];
  // stop-all, default and buffer clear each wipe every status bit
  assign clr_all = cmd_wr & (|WB_DAT_I[CMD_CLRF_BIT:CMD_DEFAULT_BIT]); // R9
  // receive start restarts the buffer, dropping any unread bytes
  assign fifo_clr = set_def | (cmd_wr & WB_DAT_I[CMD_CLRF_BIT]) | RX_START; // R16
  assign host_push = wr_req & (WB_ADR_I == OFS_FDATA) & WB_SEL_I[0];
  assign host_pop = rd_req & (WB_ADR_I == OFS_FDATA);
  assign wlvl_m = merge16({6'h00, wlvl_ff}, WB_DAT_I, WB_SEL_I);
  assign txlen_m = merge16({3'h0, txlen_ff}, WB_DAT_I, WB_SEL_I);
  assign fstat = 32'(f.count) | (32'(ovf_ff) << FST_OVF_BIT) | (32'(unf_ff) << FST_UNF_BIT); // R11
  assign rd_mux = stat_hit ? {24'h000000, stat_ff[idx]} :
                  mask_hit ? {24'h000000, mask_ff[idx]} :
                  (WB_ADR_I == OFS_FDATA) ? {24'h000000, f.rdata} : // R17
                  (WB_ADR_I == OFS_FSTAT) ? fstat :
                  (WB_ADR_I == OFS_WLVL) ? {22'h000000, wlvl_ff} :
                  (WB_ADR_I == OFS_TXLEN) ? {19'h00000, txlen_ff} :
                  (WB_ADR_I == OFS_MODE) ? {26'h0000000, rate_ff, mode_ff} :
                  (WB_ADR_I == OFS_CTRL) ? {29'h00000000, ctrl_ff} : 32'h00000000;

  // bus answer registers; unmapped addresses ack with zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req;
      dat_ff <= rd_req ? rd_mux : dat_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // internal event sources
  logic rate_mode;
  logic rate_evt;
  logic wl_below;
  logic wl_evt;
  logic slot_evt;
  assign rate_mode = TARGET_MODE & mode_ff[MODE_AUTO_BIT];
  assign rate_evt = RX_START & rate_mode; // R18
  assign wl_below = {6'h00, f.count} < {6'h00, wlvl_ff};
  // edge of the crossing only, so a drained buffer does not re-flag forever
  assign wl_evt = TX_ACTIVE & wl_below & ~wl_below_ff; // R21
  assign slot_evt = SLOT_USE & (slot_used_ff == SLOT_LOW_AT); // R19
  assign evt[0] = EVT_MAIN | (8'(wl_evt) << MAIN_WL_BIT) | (8'(RX_END) << MAIN_RXE_BIT); // R22
  assign evt[1] = EVT_TIMER | (8'(rate_evt) << TMR_RATE_BIT);
  assign evt[2] = EVT_ERR | (8'(FIELD_ON) << ERR_EON_BIT);
  assign evt[3] = EVT_PT | (8'(slot_evt) << PT_SLWL_BIT);

  //////////////////////////////////////////////////////////////////////////////
  // four status/mask pairs; a set in the clearing cycle survives
  for (genvar i = 0; i < NUM_STAT; i++) begin : g_stat // R1
    logic rd_clr;
    logic mask_wr;
    // read clears masked bits the same as unmasked ones
    assign rd_clr = rd_req & stat_hit & (idx == 2'(i)); // R4 R7
    assign mask_wr = wr_req & mask_hit & (idx == 2'(i)) & WB_SEL_I[0];
    assign nxt_stat[i] = (stat_ff[i] & ~{8{rd_clr | clr_all}}) | evt[i]; // R2 R9
    assign nxt_mask[i] = set_def ? MASK_RST : mask_wr ? WB_DAT_I[7:0] : mask_ff[i];
    assign pend[i] = |(nxt_stat[i] & ~nxt_mask[i]); // R6 R8
    assign cur_pend[i] = |(stat_ff[i] & ~mask_ff[i]);
  end

  // irq follows next-state so it drops on the reading edge itself
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_ff <= '{default: 8'h00};
      mask_ff <= '{default: MASK_RST};
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      irq_ff <= |pend; // R5 R23
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // buffer ports: receive has priority; a host write colliding with a receive byte is lost
  logic push;
  logic pop;
  logic ovf_evt;
  logic unf_evt;
  assign push = RX_PUSH | host_push;
  assign pop = TX_POP | host_pop;
  assign f.push = push;
  assign f.wdata = RX_PUSH ? RX_BYTE : WB_DAT_I[7:0];
  assign f.pop = pop;
  assign f.clr = fifo_clr;
  assign ovf_evt = push & f.full; // R12 R13
  assign unf_evt = pop & f.empty; // R14 R15

  hif_fifo u_fifo ( // R10
    .clk(CLK),
    .rst_n(RST_N),
    .f(f)
  );

  // error flags restart with the pointers, but a fresh error in that cycle sticks
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
      wl_below_ff <= 1'b0;
      tx_data_ff <= 8'h00;
    end else begin
      ovf_ff <= (ovf_ff & ~fifo_clr) | ovf_evt; // R16
      unf_ff <= (unf_ff & ~fifo_clr) | unf_evt;
      wl_below_ff <= wl_below;
      tx_data_ff <= TX_POP ? f.rdata : tx_data_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic cfg_wr_wl;
  logic cfg_wr_tl;
  logic cfg_wr_md;
  logic cfg_wr_ct;
  assign cfg_wr_wl = wr_req & (WB_ADR_I == OFS_WLVL);
  assign cfg_wr_tl = wr_req & (WB_ADR_I == OFS_TXLEN);
  assign cfg_wr_md = wr_req & (WB_ADR_I == OFS_MODE) & WB_SEL_I[0];
  assign cfg_wr_ct = wr_req & (WB_ADR_I == OFS_CTRL) & WB_SEL_I[0];

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wlvl_ff <= WLVL_RST;
      txlen_ff <= TXLEN_RST;
      mode_ff <= MODE_RST;
      ctrl_ff <= CTRL_RST;
      rate_ff <= 2'h0;
    end else if (set_def) begin
      wlvl_ff <= WLVL_RST;
      txlen_ff <= TXLEN_RST;
      mode_ff <= MODE_RST;
      ctrl_ff <= CTRL_RST;
      rate_ff <= 2'h0;
    end else begin
      wlvl_ff <= cfg_wr_wl ? wlvl_m[9:0] : wlvl_ff;
      txlen_ff <= cfg_wr_tl ? txlen_m[12:0] : txlen_ff;
      mode_ff <= cfg_wr_md ? WB_DAT_I[3:0] : mode_ff;
      ctrl_ff <= cfg_wr_ct ? WB_DAT_I[2:0] : ctrl_ff;
      rate_ff <= rate_evt ? RATE_IN : rate_ff; // R18
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // slot number usage; saturates so an over-use cannot wrap back to the warning
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      slot_used_ff <= 5'h00;
    end else if (SLOT_RELOAD) begin
      slot_used_ff <= 5'h00;
    end else if (SLOT_USE && slot_used_ff != TSN_TOTAL) begin
      slot_used_ff <= slot_used_ff + 5'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // low-power field wake: window closes on host confirm or on timeout
  logic confirmed;
  logic wake_start;
  assign confirmed = ctrl_ff[CTRL_EN_BIT] & ctrl_ff[CTRL_RXEN_BIT];
  assign wake_start = FIELD_ON & ~ctrl_ff[CTRL_EN_BIT]; // R20
  always_comb begin
    nxt_wake = wake_ff;
    unique case (wake_ff)
      WK_SLEEP: begin
        if (wake_start) begin
          nxt_wake = WK_AWAKE;
        end
      end
      WK_AWAKE: begin
        if (confirmed || wake_cnt_ff == '0) begin
          nxt_wake = WK_SLEEP; // R20
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wake_ff <= WK_SLEEP;
      wake_cnt_ff <= '0;
      field_wake_ff <= 1'b0;
    end else begin
      wake_ff <= nxt_wake;
      wake_cnt_ff <= (wake_ff == WK_SLEEP) ? WAKE_W'(WAKE_CYCLES - 1)
                     : (wake_cnt_ff - WAKE_W'(1));
      field_wake_ff <= (nxt_wake == WK_AWAKE);
    end
  end
  // outputs straight from flops
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;
  assign IRQ = irq_ff;
  assign TX_DATA = tx_data_ff;
  assign TX_LEN = txlen_ff;
  assign OP_MODE = mode_ff;
  assign FIELD_WAKE = field_wake_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_irq_or_gate: assert property (##1 IRQ == |cur_pend) // R23
    else $error("irq differs from pending and mask");
  a_event_sets: assert property (|EVT_MAIN |=> &(stat_ff[0] | ~$past(EVT_MAIN))) // R2
    else $error("main event did not set status");
  a_masked_quiet: assert property ((cur_pend == '0) |-> !IRQ) // R6
    else $error("irq high with only masked bits");
  a_unmask_raise: assert property (mask_wr_any && idx == 2'h0 // R8
                                   && |(stat_ff[0] & ~WB_DAT_I[7:0]) |=> IRQ)
    else $error("unmasked pending bit did not raise irq");
  a_read_data: assert property ((rd_req && stat_hit && idx == 2'h0) // R4
                                 |=> WB_ACK_O && WB_DAT_O[7:0] == $past(stat_ff[0]))
    else $error("status read returned wrong value");
  a_read_clears: assert property ((rd_req && stat_hit && idx == 2'h0 && evt[0] == 8'h00) // R7
                                   |=> stat_ff[0] == 8'h00)
    else $error("status read did not clear");
  a_cmd_clear: assert property ((clr_all && evt[1] == 8'h00) |=> stat_ff[1] == 8'h00) // R9
    else $error("command did not clear status");
  a_ovf_flag: assert property (ovf_evt |=> ovf_ff) // R13
    else $error("overflow not flagged");
  a_unf_flag: assert property (unf_evt |=> unf_ff) // R14
    else $error("underflow not flagged");
  a_empty_zero: assert property ((host_pop && f.empty) |=> WB_DAT_O == 32'h00000000) // R17
    else $error("empty buffer read not zero");
  a_fifo_reset: assert property ((fifo_clr && !push && !pop) // R16
                                 |=> f.count == '0 && !ovf_ff && !unf_ff)
    else $error("buffer not reset");
  a_rate_irq: assert property (rate_evt // R18
                               |=> stat_ff[1][TMR_RATE_BIT] && rate_ff == $past(RATE_IN))
    else $error("rate interrupt or rate missing");
  a_slot_low: assert property (slot_evt |=> stat_ff[3][PT_SLWL_BIT]) // R19
    else $error("slot level interrupt missing");
  a_water_irq: assert property (wl_evt |=> stat_ff[0][MAIN_WL_BIT]) // R21
    else $error("water level interrupt missing");
  a_wake_close: assert property ((wake_ff == WK_AWAKE && confirmed) |=> !FIELD_WAKE) // R20
    else $error("wake window not closed on confirm");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");

  c_irq_rise: cover property (!IRQ ##1 IRQ ##[1:20] !IRQ);
  c_overflow: cover property (ovf_evt);
  c_underflow: cover property (unf_evt && TX_ACTIVE);
  c_wake: cover property (wake_start ##[1:50] confirmed);
endmodule // hif_irq_fifo

// [test/hif_fe_model.sv]
// front-end model: framer pops and receiver pushes into the byte buffer
module hif_fe_model (
  input wire logic clk,
  output logic tx_pop,
  output logic rx_start,
  output logic rx_push,
  output logic [7:0] rx_byte,
  output logic rx_end
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {tx_pop, rx_start, rx_push, rx_end} = 4'h0;
    rx_byte = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one frame: start, n bytes with gap idle cycles between, end
  task automatic rx(input int n, input int gap);
    @(posedge clk);
    rx_start <= 1'b1;
    @(posedge clk);
    rx_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      rx_push <= 1'b1;
      rx_byte <= 8'(i) ^ 8'hA5;
      @(posedge clk);
      if (gap > 0) begin
        rx_push <= 1'b0;
        rx_byte <= ~rx_byte; // stale byte never left on the line
        repeat (gap) @(posedge clk);
      end
    end
    rx_push <= 1'b0;
    rx_end <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
  endtask
  // framer takes n bytes back to back, also past empty
  task automatic pop(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tx_pop <= 1'b1;
    end
    @(posedge clk);
    tx_pop <= 1'b0;
  endtask
endmodule // hif_fe_model

// [test/hif_irq_fifo_tb.sv]
// self-checking bench for the interrupt and buffer block
module hif_irq_fifo_tb;
  import hif_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic tmode = 1'b0, txa = 1'b0;
  logic [2:0] pul = 3'h0;
  logic [7:0] adr = 8'h00, v, txd, rb;
  logic [31:0] dw = 32'h0, q, rnd = 32'h24, dr;
  logic [3:0][7:0] evt = '0;
  logic [1:0] rate = 2'h0;
  logic ack, irq, fwake, pop, rs, rp, re;
  logic [12:0] txl;
  logic [3:0] opm;
  int mismatches = 0, cmp_count = 0;
  always #20 clk = ~clk;
  hif_irq_fifo #(.WAKE_CYCLES(20)) hif_irq_fifo_i (
    .CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dw), .WB_ACK_O(ack), .WB_DAT_O(dr),
    .EVT_MAIN(evt[0]), .EVT_TIMER(evt[1]), .EVT_ERR(evt[2]), .EVT_PT(evt[3]),
    .TARGET_MODE(tmode), .TX_ACTIVE(txa), .TX_POP(pop), .RX_START(rs), .RX_PUSH(rp),
    .RX_BYTE(rb), .RX_END(re), .RATE_IN(rate), .SLOT_USE(pul[0]), .SLOT_RELOAD(pul[1]),
    .FIELD_ON(pul[2]), .IRQ(irq), .TX_DATA(txd), .TX_LEN(txl), .OP_MODE(opm),
    .FIELD_WAKE(fwake));
  hif_fe_model hif_fe_model_i (.clk(clk), .tx_pop(pop), .rx_start(rs), .rx_push(rp),
    .rx_byte(rb), .rx_end(re));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h wanted %h", $time, got, exp);
    end
  endtask
  // classic cycle; no fixed latency assumed, wait bounded
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk(ack, 1);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic ev(input int k, input logic [7:0] x);
    @(posedge clk);
    evt[k] <= x;
    @(posedge clk);
    evt[k] <= 8'h00;
    @(posedge clk);
  endtask
  task automatic pl(input int b, input int n);
    repeat (n) begin
      @(posedge clk);
      pul[b] <= 1'b1;
      @(posedge clk);
      pul[b] <= 1'b0;
    end
    @(posedge clk);
  endtask
  function automatic logic [31:0] fs(input int c, input logic o, input logic u);
    return {18'h0, u, o, 2'h0, 10'(c)};
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // watchdog: whole sequence needs well under 10k cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped place, empty buffer
    rd(OFS_MASK, 32'h0);
    rd(OFS_WLVL, 32'(WLVL_RST));
    rd(8'h3C, 32'h0);
    rd(OFS_FSTAT, fs(0, 0, 0));
    rd(OFS_FDATA, 32'h0);
    rd(OFS_FSTAT, fs(0, 0, 1));
    wr(OFS_CMD, 32'h4);
    rd(OFS_FSTAT, fs(0, 0, 0));
    $display("reset test done");
    // each status register sets, raises the line, clears on read
    for (int k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      v = rnd[7:0] | 8'h01;
      ev(k, v);
      chk(irq, 1);
      rd(8'(k * 4), {24'h0, v});
      chk(irq, 0);
      rd(8'(k * 4), 32'h0);
    end
    ev(0, 8'h01);
    ev(2, 8'h80);
    rd(OFS_STAT, 32'h01);
    chk(irq, 1);
    rd(OFS_STAT + 8'h08, 32'h80);
    chk(irq, 0);
    // masking hides the line only
    wr(OFS_MASK, 32'hFF);
    ev(0, 8'h40);
    chk(irq, 0);
    wr(OFS_MASK, 32'h00);
    chk(irq, 1);
    wr(OFS_MASK, 32'hFF);
    rd(OFS_STAT, 32'h40);
    wr(OFS_MASK, 32'h00);
    for (int c = 1; c < 8; c = c * 2) begin
      ev(1, 8'h22);
      wr(OFS_CMD, 32'(c));
      chk(irq, 0);
      rd(OFS_STAT + 8'h04, 32'h0);
    end
    $display("status test done");
    // host fill up to capacity, then one byte too many
    for (int i = 0; i < 513; i++) begin
      if (i == 512) rd(OFS_FSTAT, fs(512, 0, 0));
      wr(OFS_FDATA, {24'h0, i[7:0]});
    end
    rd(OFS_FSTAT, fs(512, 1, 0));
    // reception restarts the full buffer
    hif_fe_model_i.rx(3, 2);
    rd(OFS_FSTAT, fs(3, 0, 0));
    rd(OFS_STAT, 32'h10);
    for (int i = 0; i < 3; i++) rd(OFS_FDATA, {24'h0, 8'(i) ^ 8'hA5});
    rd(OFS_FDATA, 32'h0);
    rd(OFS_FSTAT, fs(0, 0, 1));
    hif_fe_model_i.rx(513, 0);
    rd(OFS_FSTAT, fs(512, 1, 0));
    wr(OFS_CMD, 32'h4);
    $display("buffer test done");
    // rate detection when listening with auto rate
    wr(OFS_MODE, 32'h08);
    chk(opm, 4'h8);
    tmode <= 1'b1;
    rnd = xs(rnd);
    rate <= rnd[1:0];
    hif_fe_model_i.rx(1, 0);
    rd(OFS_STAT + 8'h04, 32'h01);
    rd(OFS_MODE, {26'h0, rnd[1:0], 4'h8});
    wr(OFS_CMD, 32'h4);
    // slot numbers: warning only when four remain
    pl(0, int'(TSN_TOTAL - TSN_LOW) - 1);
    rd(OFS_STAT + 8'h0C, 32'h0);
    pl(0, 1);
    rd(OFS_STAT + 8'h0C, 32'h04);
    pl(1, 1);
    // wake window: first left to expire, then confirmed by the host
    for (int j = 0; j < 2; j++) begin
      wr(OFS_CTRL, 32'h0);
      pl(2, 1);
      chk(fwake, 1);
      if (j == 0) repeat (30) @(posedge clk);
      else wr(OFS_CTRL, 32'h3);
      repeat (2) @(posedge clk);
      chk(fwake, 0);
    end
    rd(OFS_STAT + 8'h08, 32'h02);
    $display("event test done");
    // transmit: water level crossing, popped byte, starved framer
    for (int i = 0; i <= int'(WLVL_RST); i++) wr(OFS_FDATA, {24'h0, i[7:0]});
    wr(OFS_TXLEN, 32'(WLVL_RST) + 32'h1);
    chk(txl, 13'(WLVL_RST) + 13'h1);
    txa <= 1'b1;
    hif_fe_model_i.pop(1);
    rd(OFS_STAT, 32'h0);
    hif_fe_model_i.pop(1);
    @(posedge clk);
    chk(txd, 8'h01);
    rd(OFS_STAT, 32'h08);
    hif_fe_model_i.pop(int'(WLVL_RST));
    rd(OFS_FSTAT, fs(0, 0, 1));
    txa <= 1'b0;
    $display("transmit test done");
    results();
  end
endmodule // hif_irq_fifo_tb
